// File: hw/fast_threshold_detect.v
// fast threshold detector with overrange delay and serial register port
//
// Behaviour
// R1: detection runs only while bit 0 of control register detect_control is set.
// R2: flag output stays low while sample magnitude is below the threshold.
// R3: comparisons use sample magnitude only; sign is ignored.
// R4: flag asserts when magnitude exceeds upper threshold at upper_threshold_a/upper_threshold_b.
// R5: upper comparison reaches the flag output seven cycles after the sample.
// R6: set flag clears only after magnitude stays below lower threshold for dwell.
// R7: lower threshold is sixteen bits at lower_threshold_a/lower_threshold_b, compared to output magnitude.
// R8: dwell is 1 to 65535 sample cycles from registers dwell_time_a/dwell_time_b.
// R9: thresholds are scaled so magnitude two to the thirteenth is full scale.
// R10: overrange indicator rises 36 cycles after input overrange.
// R11: dwell counter restarts when magnitude reaches the lower threshold early.
`timescale 1ns/100ps
`include "fast_threshold_detect_map.vh"

module fast_threshold_detect #(
    parameter SAMPLE_WIDTH = 14,
    parameter THR_WIDTH    = 16
) (
    input  wire                    sys_clk_in,        // sample clock, 10 MHz
    input  wire                    resetn_in,         // async reset, active low
    input  wire [SAMPLE_WIDTH-1:0] sample_in,         // twos complement pipeline output
    input  wire                    ovr_at_input_in,   // overrange seen at converter input
    input  wire                    sclk_in,           // serial port clock pin
    input  wire                    csn_in,            // serial port select pin, active low
    input  wire                    sdio_in,           // serial data pin, input side
    output wire                    sdio_out,          // serial data pin, output side
    output wire                    sdio_oe_out,       // serial data pin drive enable
    output wire                    over_threshold_out,// fast over-threshold flag
    output wire                    overrange_out      // delayed overrange indicator
);

    localparam CMP_STAGES = `UPPER_DETECT_LATENCY - 3;
    localparam OVR_STAGES = `OVERRANGE_LATENCY;

    // reset release
    // assert at once, release on one edge so no flop leaves reset a cycle early
    reg rst_meta_reg;
    reg rst_n_reg;
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // serial pin synchronisers; edges come from the second and third stages only
    reg [2:0] sclk_sync_reg;
    reg [1:0] csn_sync_reg;
    reg [1:0] sdi_sync_reg;
    always @(posedge sys_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sclk_sync_reg <= 3'h0;
            csn_sync_reg  <= 2'h3;
            sdi_sync_reg  <= 2'h0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_in};
            csn_sync_reg  <= {csn_sync_reg[0], csn_in};
            sdi_sync_reg  <= {sdi_sync_reg[0], sdio_in};
        end
    end

    wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
    wire cs_active = ~csn_sync_reg[1];
    wire sdi_bit   = sdi_sync_reg[1];

    // registers
    reg [7:0]           control_reg;
    reg [THR_WIDTH-1:0] upper_thr_reg;
    reg [THR_WIDTH-1:0] lower_thr_reg;
    reg [THR_WIDTH-1:0] dwell_reg;

    // serial port state
    reg [4:0]  bit_cnt_reg;      // counts instruction bits up to 16
    reg [14:0] instr_reg;
    reg        rd_mode_reg;
    reg [1:0]  len_reg;
    reg [12:0] addr_reg;
    reg [2:0]  data_bit_reg;
    reg [6:0]  data_shift_reg;
    reg [1:0]  bytes_done_reg;
    reg        frame_over_reg;
    reg [7:0]  rd_byte_reg;
    reg        sdo_reg;

    // sixteen instruction bits, then data until select rises
    wire in_instr = (bit_cnt_reg != 5'd16);

    function [7:0] read_reg;
        input [12:0] a;
        begin
            case (a)
                `ADDR_DETECT_CONTROL:    read_reg = control_reg;
                `ADDR_UPPER_THRESHOLD_A: read_reg = upper_thr_reg[7:0];
                `ADDR_UPPER_THRESHOLD_B: read_reg = upper_thr_reg[15:8];
                `ADDR_LOWER_THRESHOLD_A: read_reg = lower_thr_reg[7:0];
                `ADDR_LOWER_THRESHOLD_B: read_reg = lower_thr_reg[15:8];
                `ADDR_DWELL_TIME_A:      read_reg = dwell_reg[7:0];
                `ADDR_DWELL_TIME_B:      read_reg = dwell_reg[15:8];
                default:                 read_reg = 8'h00;
            endcase
        end
    endfunction

    // write lands a few sample cycles after the eighth data edge; no acknowledge
    // so the host must leave that time before reading back
    wire [7:0]  wr_byte    = {data_shift_reg, sdi_bit};
    wire        byte_done  = ~in_instr & (data_bit_reg == 3'd7) & sclk_rise & cs_active;
    wire        wr_strobe  = byte_done & ~rd_mode_reg & ~frame_over_reg;
    wire [12:0] first_addr = instr_reg[12:0];
    wire        last_byte  = (len_reg != `LEN_STREAMING) & (bytes_done_reg == len_reg);

    always @(posedge sys_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            bit_cnt_reg    <= 5'd0;
            instr_reg      <= 15'h0000;
            rd_mode_reg    <= 1'b0;
            len_reg        <= 2'h0;
            addr_reg       <= 13'h0000;
            data_bit_reg   <= 3'd0;
            data_shift_reg <= 7'h00;
            bytes_done_reg <= 2'h0;
            frame_over_reg <= 1'b0;
            rd_byte_reg    <= 8'h00;
            sdo_reg        <= 1'b0;
        end else if (!cs_active) begin
            // a raised select aborts the frame
            // only whole bytes are written, so a cut byte leaves its register intact
            bit_cnt_reg    <= 5'd0;
            data_bit_reg   <= 3'd0;
            bytes_done_reg <= 2'h0;
            frame_over_reg <= 1'b0;
            rd_mode_reg    <= 1'b0;
        end else if (sclk_rise) begin
            if (in_instr) begin
                instr_reg   <= {instr_reg[13:0], sdi_bit};
                bit_cnt_reg <= bit_cnt_reg + 5'd1;
                if (bit_cnt_reg == 5'd15) begin
                    rd_mode_reg <= instr_reg[14];
                    len_reg     <= instr_reg[13:12];
                    addr_reg    <= {instr_reg[11:0], sdi_bit};
                    rd_byte_reg <= read_reg({instr_reg[11:0], sdi_bit});
                end
            end else begin
                data_shift_reg <= {data_shift_reg[5:0], sdi_bit};
                data_bit_reg   <= data_bit_reg + 3'd1;
                if (data_bit_reg == 3'd7) begin
                    // streaming walks the map downward
                    addr_reg    <= addr_reg - 13'd1;
                    rd_byte_reg <= read_reg(addr_reg - 13'd1);
                    if (last_byte)
                        frame_over_reg <= 1'b1;
                    else
                        bytes_done_reg <= bytes_done_reg + 2'h1;
                end
            end
        end else if (sclk_fall && !in_instr) begin
            sdo_reg <= rd_byte_reg[3'd7 - data_bit_reg];
        end
    end

    assign sdio_out    = sdo_reg;
    assign sdio_oe_out = cs_active & ~in_instr & rd_mode_reg & ~frame_over_reg;

    always @(posedge sys_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            control_reg   <= `RST_DETECT_CONTROL;
            upper_thr_reg <= `RST_UPPER_THRESHOLD;
            lower_thr_reg <= `RST_LOWER_THRESHOLD;
            dwell_reg     <= `RST_DWELL_TIME;
        end else if (wr_strobe) begin
            case (addr_reg)
                `ADDR_DETECT_CONTROL:    control_reg          <= wr_byte;
                `ADDR_UPPER_THRESHOLD_A: upper_thr_reg[7:0]   <= wr_byte; // see R4
                `ADDR_UPPER_THRESHOLD_B: upper_thr_reg[15:8]  <= wr_byte; // see R4
                `ADDR_LOWER_THRESHOLD_A: lower_thr_reg[7:0]   <= wr_byte; // see R7
                `ADDR_LOWER_THRESHOLD_B: lower_thr_reg[15:8]  <= wr_byte; // see R7
                `ADDR_DWELL_TIME_A:      dwell_reg[7:0]       <= wr_byte; // see R8
                `ADDR_DWELL_TIME_B:      dwell_reg[15:8]      <= wr_byte; // see R8
                default: ;
            endcase
        end
    end

    wire detect_en = control_reg[`DETECT_ENABLE_BIT];

    // stage 1: magnitude; -8192 gives 8192, which is full scale
    // the wider compare width keeps that one extra value from wrapping
    reg [THR_WIDTH-1:0] mag_reg;
    wire [SAMPLE_WIDTH-1:0] neg_sample = ~sample_in + {{(SAMPLE_WIDTH-1){1'b0}}, 1'b1};
    wire [SAMPLE_WIDTH-1:0] abs_sample = sample_in[SAMPLE_WIDTH-1] ? neg_sample : sample_in;
    always @(posedge sys_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg)
            mag_reg <= {THR_WIDTH{1'b0}};
        else
            mag_reg <= {{(THR_WIDTH-SAMPLE_WIDTH){1'b0}}, abs_sample}; // see R3, R9
    end

    // stage 2: both comparisons on the same magnitude so they stay aligned
    reg above_reg;
    reg below_reg;
    always @(posedge sys_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            above_reg <= 1'b0;
            below_reg <= 1'b0;
        end else begin
            above_reg <= (mag_reg > upper_thr_reg); // see R4
            below_reg <= (mag_reg < lower_thr_reg); // see R7
        end
    end

    // stages 3 to 6: pad to the fixed detect latency
    // lower compare shares the delay so a set and a clear never cross
    reg [CMP_STAGES-1:0] above_dl_reg;
    reg [CMP_STAGES-1:0] below_dl_reg;
    genvar i;
    generate
        for (i = 0; i < CMP_STAGES; i = i + 1) begin : g_cmp_delay
            always @(posedge sys_clk_in or negedge rst_n_reg) begin
                if (!rst_n_reg) begin
                    above_dl_reg[i] <= 1'b0;
                    below_dl_reg[i] <= 1'b0;
                end else begin
                    above_dl_reg[i] <= (i == 0) ? above_reg : above_dl_reg[(i == 0) ? 0 : i-1]; // see R5
                    below_dl_reg[i] <= (i == 0) ? below_reg : below_dl_reg[(i == 0) ? 0 : i-1];
                end
            end
        end
    endgenerate

    wire above_d = above_dl_reg[CMP_STAGES-1];
    wire below_d = below_dl_reg[CMP_STAGES-1];

    // stage 7: flag with hysteresis and dwell
    // an above sample wins over the dwell count, so a burst re-arms the hold
    reg                 flag_reg;
    reg                 flag_next;
    reg [THR_WIDTH-1:0] dwell_cnt_reg;
    reg [THR_WIDTH-1:0] dwell_cnt_next;
    // a dwell of zero would clear on the first below sample; treat it as one
    wire [THR_WIDTH-1:0] dwell_eff = (dwell_reg == {THR_WIDTH{1'b0}}) ? {{(THR_WIDTH-1){1'b0}}, 1'b1} : dwell_reg;
    wire [THR_WIDTH-1:0] dwell_inc = dwell_cnt_reg + {{(THR_WIDTH-1){1'b0}}, 1'b1};

    always @* begin
        flag_next      = flag_reg;
        dwell_cnt_next = dwell_cnt_reg;
        if (!detect_en) begin
            flag_next      = 1'b0; // see R1
            dwell_cnt_next = {THR_WIDTH{1'b0}};
        end else if (above_d) begin
            flag_next      = 1'b1; // see R4
            dwell_cnt_next = {THR_WIDTH{1'b0}};
        end else if (flag_reg) begin
            if (below_d) begin
                if (dwell_inc >= dwell_eff) begin
                    flag_next      = 1'b0; // see R6, R8
                    dwell_cnt_next = {THR_WIDTH{1'b0}};
                end else begin
                    dwell_cnt_next = dwell_inc;
                end
            end else begin
                dwell_cnt_next = {THR_WIDTH{1'b0}}; // see R11
            end
        end else begin
            dwell_cnt_next = {THR_WIDTH{1'b0}}; // see R2
        end
    end

    always @(posedge sys_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            flag_reg      <= 1'b0;
            dwell_cnt_reg <= {THR_WIDTH{1'b0}};
        end else begin
            flag_reg      <= flag_next;
            dwell_cnt_reg <= dwell_cnt_next;
        end
    end

    assign over_threshold_out = flag_reg;

    // overrange: fixed pipeline delay
    // plain shift line: the indicator is delayed, never filtered
    reg [OVR_STAGES-1:0] ovr_dl_reg;
    generate
        for (i = 0; i < OVR_STAGES; i = i + 1) begin : g_ovr_delay
            always @(posedge sys_clk_in or negedge rst_n_reg) begin
                if (!rst_n_reg)
                    ovr_dl_reg[i] <= 1'b0;
                else
                    ovr_dl_reg[i] <= (i == 0) ? ovr_at_input_in : ovr_dl_reg[(i == 0) ? 0 : i-1]; // see R10
            end
        end
    endgenerate

    assign overrange_out = ovr_dl_reg[OVR_STAGES-1];

endmodule // fast_threshold_detect

// File: pkg/fast_threshold_detect_map.vh
// register map, reset values and latencies of the fast threshold detector
`ifndef FAST_THRESHOLD_DETECT_MAP_VH
`define FAST_THRESHOLD_DETECT_MAP_VH

// register offsets on the serial port
`define ADDR_DETECT_CONTROL     13'h0045
`define ADDR_UPPER_THRESHOLD_A  13'h0047
`define ADDR_UPPER_THRESHOLD_B  13'h0048
`define ADDR_LOWER_THRESHOLD_A  13'h0049
`define ADDR_LOWER_THRESHOLD_B  13'h004a
`define ADDR_DWELL_TIME_A       13'h004b
`define ADDR_DWELL_TIME_B       13'h004c

// field positions
`define DETECT_ENABLE_BIT       0
`define INSTR_READ_BIT          15
`define INSTR_LEN_HI            14
`define INSTR_LEN_LO            13

// reset values
`define RST_DETECT_CONTROL      8'h00
`define RST_UPPER_THRESHOLD     16'h0000
`define RST_LOWER_THRESHOLD     16'h0000
`define RST_DWELL_TIME          16'h0001

// serial word length encodings
`define LEN_STREAMING           2'h3

// latencies in sample clock cycles
`define UPPER_DETECT_LATENCY    7
`define OVERRANGE_LATENCY       36

`endif

// File: verification/fast_threshold_detect_asserts.sv
// port-level assertions for the fast threshold detector
`timescale 1ns/100ps
module fast_threshold_detect_asserts #(
    parameter SAMPLE_WIDTH = 14
) (
    input wire                    sys_clk_in,         // clock
    input wire                    resetn_in,          // reset
    input wire [SAMPLE_WIDTH-1:0] sample_in,          // sample
    input wire                    ovr_at_input_in,    // overrange in
    input wire                    sclk_in,            // serial clock
    input wire                    csn_in,             // select
    input wire                    sdio_out,           // read data
    input wire                    sdio_oe_out,        // drive enable
    input wire                    over_threshold_out, // flag
    input wire                    overrange_out       // overrange out
);
    // keeps $past away from values launched during reset
    reg [5:0] cyc_reg;
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) cyc_reg <= 6'h00;
        else if (cyc_reg != 6'h3f) cyc_reg <= cyc_reg + 6'h01;
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    a_ovr_delay: assert property (cyc_reg > 6'h28 |-> overrange_out == $past(ovr_at_input_in, 36))
        else $error("overrange output is not the delayed input");
    a_ovr_rise: assert property ($rose(ovr_at_input_in) |-> ##36 $rose(overrange_out))
        else $error("overrange output did not rise on time");
    a_ovr_fall: assert property ($fell(ovr_at_input_in) |-> ##36 $fell(overrange_out))
        else $error("overrange output did not fall on time");
    a_flag_cause: assert property ($rose(over_threshold_out) |-> $past(sample_in, 7) != 0)
        else $error("flag rose without a nonzero sample seven cycles before");
    a_reset_quiet: assert property ($rose(resetn_in) |-> !over_threshold_out && !overrange_out && !sdio_oe_out)
        else $error("outputs active on leaving reset");
    a_oe_needs_csn: assert property ($rose(sdio_oe_out) |-> !csn_in)
        else $error("data pin driven without select");
    a_oe_idle: assert property (csn_in [*5] |-> !sdio_oe_out)
        else $error("data pin still driven after select went high");
    a_sdio_clk_low: assert property (sdio_oe_out && $past(sdio_oe_out) && $changed(sdio_out) |-> !sclk_in)
        else $error("read data changed while serial clock high");
    c_flag_set: cover property ($rose(over_threshold_out));
    c_flag_clear: cover property ($fell(over_threshold_out));
    c_ovr: cover property ($rose(overrange_out));
    c_read: cover property ($rose(sdio_oe_out));
endmodule // fast_threshold_detect_asserts

// File: verification/fast_threshold_detect_tb_top.sv
// self-checking bench for the fast threshold detector
`timescale 1ns/100ps
`include "fast_threshold_detect_map.vh"
module fast_threshold_detect_tb_top;
    reg         sys_clk_in = 1'b0;
    reg         resetn_in  = 1'b0;
    reg  [13:0] level      = 14'h0000;
    reg         ovr_req    = 1'b0;
    reg         sclk       = 1'b0;
    reg         csn        = 1'b1;
    reg         host_sdio  = 1'b0;
    reg  [7:0]  rd;
    reg  [12:0] a;
    integer     n_mismatch = 0;
    integer     n_compared = 0;
    integer     i;
    wire [13:0] sample;
    wire        ovr, sdio_out, sdio_oe, flag, ovr_out;
    // the device wins the shared data pin while it drives
    wire        sdio_wire = sdio_oe ? sdio_out : host_sdio;
    initial forever #50 sys_clk_in = ~sys_clk_in;
    pipeline_source_model src (.sys_clk_in(sys_clk_in), .level_in(level), .ovr_req_in(ovr_req),
        .sample_out(sample), .ovr_out(ovr));
    fast_threshold_detect uut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .sample_in(sample),
        .ovr_at_input_in(ovr), .sclk_in(sclk), .csn_in(csn), .sdio_in(sdio_wire), .sdio_out(sdio_out),
        .sdio_oe_out(sdio_oe), .over_threshold_out(flag), .overrange_out(ovr_out));
    task tick(input integer n);
        integer k;
        for (k = 0; k < n; k = k + 1) begin
            @(posedge sys_clk_in);
            #1;
        end
    endtask
    task check(input [15:0] seen, input [15:0] exp, input [8*16-1:0] what);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected %0s: expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // one-byte frame; slow serial clock so the synchronisers keep up
    task spi(input rw, input [12:0] ad, input [7:0] wd);
        reg [23:0] w;
        integer b;
        begin
            w = {rw, 2'b00, ad, wd};
            csn = 1'b0;
            for (b = 23; b >= 0; b = b - 1) begin
                host_sdio = w[b];
                tick(8);
                if (b < 8) rd[b] = sdio_wire;
                sclk = 1'b1;
                tick(8);
                sclk = 1'b0;
            end
            tick(8);
            csn = 1'b1;
            tick(8);
        end
    endtask
    task rdchk(input [12:0] ad, input [7:0] e);
        begin
            spi(1'b1, ad, 8'h00);
            check({8'h00, rd}, {8'h00, e}, "register");
        end
    endtask
    task regs_scenario;
        for (i = 0; i < 8; i = i + 1) begin
            a = 13'h0045 + i[12:0];
            rdchk(a, (a == `ADDR_DWELL_TIME_A) ? 8'h01 : 8'h00);
            spi(1'b0, a, 8'ha0 + i[7:0]);
            rdchk(a, (a == 13'h0046) ? 8'h00 : 8'ha0 + i[7:0]);
        end
    endtask
    task latency_scenario;
        begin
            spi(1'b0, `ADDR_UPPER_THRESHOLD_A, 8'hff);
            spi(1'b0, `ADDR_UPPER_THRESHOLD_B, 8'h0f);
            spi(1'b0, `ADDR_LOWER_THRESHOLD_A, 8'h1d);
            spi(1'b0, `ADDR_LOWER_THRESHOLD_B, 8'h0a);
            spi(1'b0, `ADDR_DWELL_TIME_A, 8'h03);
            spi(1'b0, `ADDR_DWELL_TIME_B, 8'h00);
            spi(1'b0, `ADDR_DETECT_CONTROL, 8'h01);
            level = 14'h0fff;
            tick(12);
            check(flag, 1'b0, "flag at upper");
            for (i = 0; i < 2; i = i + 1) begin
                level = i ? 14'h3000 : 14'h1000;
                tick(7);
                check(flag, 1'b0, "early flag");
                tick(1);
                check(flag, 1'b1, "flag");
                level = 14'h0000;
                tick(12);
                check(flag, 1'b0, "flag cleared");
            end
        end
    endtask
    task dwell_scenario;
        begin
            level = 14'h1000;
            tick(10);
            level = 14'h0a1c;
            tick(2);
            level = 14'h0a1d;
            tick(1);
            level = 14'h35e4;
            tick(9);
            check(flag, 1'b1, "dwell hold");
            tick(1);
            check(flag, 1'b0, "dwell clear");
        end
    endtask
    task scale_disable_scenario;
        begin
            spi(1'b0, `ADDR_UPPER_THRESHOLD_B, 8'h1f);
            level = 14'h2000;
            tick(10);
            check(flag, 1'b1, "full scale");
            spi(1'b0, `ADDR_DETECT_CONTROL, 8'h00);
            check(flag, 1'b0, "disabled");
            level = 14'h0000;
        end
    endtask
    task ovr_scenario;
        begin
            ovr_req = 1'b1;
            tick(1);
            ovr_req = 1'b0;
            tick(35);
            check(ovr_out, 1'b0, "early overrange");
            tick(1);
            check(ovr_out, 1'b1, "overrange");
            tick(1);
            check(ovr_out, 1'b0, "overrange end");
        end
    endtask
    task end_of_test;
        begin
            if (n_mismatch == 0 && n_compared > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        tick(3);
        resetn_in = 1'b1;
        tick(3);
        regs_scenario;
        latency_scenario;
        dwell_scenario;
        scale_disable_scenario;
        ovr_scenario;
        end_of_test;
    end
endmodule // fast_threshold_detect_tb_top
bind fast_threshold_detect fast_threshold_detect_asserts #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) chk (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .sample_in(sample_in),
    .ovr_at_input_in(ovr_at_input_in), .sclk_in(sclk_in), .csn_in(csn_in), .sdio_out(sdio_out),
    .sdio_oe_out(sdio_oe_out), .over_threshold_out(over_threshold_out), .overrange_out(overrange_out));

// File: verification/pipeline_source_model.sv
// stand-in for the converter pipeline feeding samples and overrange
`timescale 1ns/100ps
module pipeline_source_model (
    input  wire        sys_clk_in, // sample clock
    input  wire [13:0] level_in,   // next sample
    input  wire        ovr_req_in, // next overrange
    output reg  [13:0] sample_out, // twos complement sample
    output reg         ovr_out     // overrange at input
);
    initial begin
        sample_out = 14'h0000;
        ovr_out = 1'b0;
    end
    // a fresh sample every edge, like the real pipeline
    always @(posedge sys_clk_in) begin
        sample_out <= level_in;
        ovr_out <= ovr_req_in;
    end
endmodule // pipeline_source_model
